// file: rar_fc_model.sv
// forward-channel side: delivers serializer ids and lock per receive port.
// assumes: send is a one-cycle request from the bench, same clock.
`timescale 1ns/1ps
module rar_fc_model #(
	parameter int NP = 4
) (
	input  wire logic            clock,
	input  wire logic            rst,
	input  wire logic            send,
	input  wire logic [1:0]      port,
	input  wire logic [6:0]      id,
	output logic      [NP-1:0]   fc_id_valid,
	output logic      [NP*7-1:0] fc_id,
	output logic      [NP-1:0]   fc_lock
);
	always_ff @(posedge clock) begin
		fc_id_valid <= '0;
		// idle lanes toggle so a stale id is never seen as valid data
		fc_id <= rst ? {NP{7'h55}} : ~fc_id;
		if (rst) begin
			fc_lock <= '0;
		end else if (send) begin
			fc_id_valid[port] <= 1'b1;
			fc_id[port*7+:7]  <= id;
			fc_lock[port]     <= 1'b1;
		end
	end
endmodule

// file: rar_pkg.sv
// rar_pkg: shared constants for the remote I2C alias / remap register bank.
// assumes: byte-wide register access from a local I2C target, one 100 MHz clock.
package rar_pkg;

	// register data and I2C address widths, target entries per port, port limit and port select width
	localparam int RAR_DW         = 8;
	localparam int RAR_AW         = 7;
	localparam int RAR_NUM_TGT    = 3;
	localparam int RAR_MAX_PORTS  = 4;
	localparam int RAR_PSEL_W     = 2;

	// register offsets
	localparam logic [7:0] RAR_OFS_PORT_SEL  = 8'h4C;
	localparam logic [7:0] RAR_OFS_SER_ADDR  = 8'h5B;
	localparam logic [7:0] RAR_OFS_SER_ALIAS = 8'h5C;
	localparam logic [7:0] RAR_OFS_TGT0      = 8'h5D;
	localparam logic [7:0] RAR_OFS_TGT1      = 8'h5E;
	localparam logic [7:0] RAR_OFS_TGT2      = 8'h5F;

	// field positions
	localparam int RAR_ADDR_MSB = 7;
	localparam int RAR_ADDR_LSB = 1;
	localparam int RAR_HOLD_BIT = 0;
	localparam int RAR_AACK_BIT = 0;
	localparam int RAR_PSEL_LSB = 0;

	// reset values and special codes
	localparam logic [7:0]        RAR_RST_VAL      = 8'h00;
	localparam logic [RAR_AW-1:0] RAR_ALIAS_OFF    = 7'h00;
	localparam logic [7:0]        RAR_UNMAPPED_VAL = 8'h00;

	// kind of decode hit for one local transaction
	typedef enum logic [1:0] {
		RAR_HIT_NONE = 2'h0,
		RAR_HIT_SER  = 2'h1,
		RAR_HIT_TGT  = 2'h3
	} rar_hit_e;

endpackage

// file: rar_port_bank.sv
// rar_port_bank: the register copy of one receive port.
// assumes: write strobe already qualified by port select; forward-channel id on the same clock.
`timescale 1ns/1ps
module rar_port_bank
	import rar_pkg::*;
(
	// clock and reset
	input  wire logic                            clock,
	input  wire logic                            rst,
	// register write from local controller
	input  wire logic                            wr_en,
	input  wire logic [7:0]                      wr_addr,
	input  wire logic [rar_pkg::RAR_DW-1:0]      wr_data,
	// forward-channel id delivery
	input  wire logic                            fc_id_valid,
	input  wire logic [rar_pkg::RAR_AW-1:0]      fc_id,
	// stored contents
	output logic      [rar_pkg::RAR_DW-1:0]      ser_addr_q,
	output logic      [rar_pkg::RAR_DW-1:0]      ser_alias_q,
	output logic      [rar_pkg::RAR_NUM_TGT*rar_pkg::RAR_AW-1:0] tgt_addr_q
);
	import rar_pkg::*;

	logic hold_w;

	assign hold_w = ser_addr_q[RAR_HOLD_BIT];

	// software write beats a same-cycle forward-channel load
	always_ff @(posedge clock) begin
		if (rst) begin
			ser_addr_q <= RAR_RST_VAL;
		end else if (wr_en && wr_addr == RAR_OFS_SER_ADDR) begin
			ser_addr_q <= wr_data;
		end else if (fc_id_valid && !hold_w) begin
			ser_addr_q[RAR_ADDR_MSB:RAR_ADDR_LSB] <= fc_id;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ser_alias_q <= RAR_RST_VAL;
		end else if (wr_en && wr_addr == RAR_OFS_SER_ALIAS) begin
			ser_alias_q <= wr_data;
		end
	end

	// bit 0 of each target entry is reserved: never stored
	genvar g;
	generate
		for (g = 0; g < RAR_NUM_TGT; g++) begin : g_tgt
			localparam logic [7:0] OFS = RAR_OFS_TGT0 + 8'(g);
			always_ff @(posedge clock) begin
				if (rst) begin
					tgt_addr_q[g*RAR_AW +: RAR_AW] <= RAR_RST_VAL[RAR_ADDR_MSB:RAR_ADDR_LSB];
				end else if (wr_en && wr_addr == OFS) begin
					tgt_addr_q[g*RAR_AW +: RAR_AW] <= wr_data[RAR_ADDR_MSB:RAR_ADDR_LSB];
				end
			end
		end
	endgenerate

endmodule

// file: rar_remap_match.sv
// rar_remap_match: combinational alias decode of one local I2C address over all ports.
// assumes: caller registers the result; lowest port, then serializer, then lowest entry wins.
`timescale 1ns/1ps
module rar_remap_match
	import rar_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	// transaction address
	input  wire logic [rar_pkg::RAR_AW-1:0]                  txn_addr,
	// per-port configuration
	input  wire logic [NUM_PORTS*rar_pkg::RAR_DW-1:0]        ser_addr,
	input  wire logic [NUM_PORTS*rar_pkg::RAR_DW-1:0]        ser_alias,
	input  wire logic [NUM_PORTS*rar_pkg::RAR_NUM_TGT*rar_pkg::RAR_AW-1:0] tgt_alias,
	input  wire logic [NUM_PORTS*rar_pkg::RAR_NUM_TGT*rar_pkg::RAR_AW-1:0] tgt_addr,
	// decode result
	output rar_pkg::rar_hit_e                                hit,
	output logic      [rar_pkg::RAR_PSEL_W-1:0]              hit_port,
	output logic      [rar_pkg::RAR_AW-1:0]                  remap_addr,
	output logic                                             hit_auto_ack
);
	import rar_pkg::*;

	localparam int NT = NUM_PORTS * RAR_NUM_TGT;

	logic [NUM_PORTS-1:0] ser_hit_w;
	logic [NT-1:0]        tgt_hit_w;

	genvar p, t;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			logic [RAR_AW-1:0] al;
			assign al = ser_alias[p*RAR_DW+RAR_ADDR_LSB +: RAR_AW];
			// zero alias never decodes
			assign ser_hit_w[p] = (al != RAR_ALIAS_OFF) && (al == txn_addr);
			for (t = 0; t < RAR_NUM_TGT; t++) begin : g_ent
				localparam int E = p*RAR_NUM_TGT + t;
				logic [RAR_AW-1:0] ta;
				assign ta = tgt_alias[E*RAR_AW +: RAR_AW];
				assign tgt_hit_w[E] = (ta != RAR_ALIAS_OFF) && (ta == txn_addr);
			end
		end
	endgenerate

	// walk from the top so the lowest index is the last, winning, assignment
	always_comb begin
		hit          = RAR_HIT_NONE;
		hit_port     = '0;
		remap_addr   = '0;
		hit_auto_ack = 1'b0;
		for (int i = NUM_PORTS-1; i >= 0; i--) begin
			for (int j = RAR_NUM_TGT-1; j >= 0; j--) begin
				if (tgt_hit_w[i*RAR_NUM_TGT+j]) begin
					hit          = RAR_HIT_TGT;
					hit_port     = RAR_PSEL_W'(i);
					remap_addr   = tgt_addr[(i*RAR_NUM_TGT+j)*RAR_AW +: RAR_AW];
					hit_auto_ack = 1'b0;
				end
			end
			if (ser_hit_w[i]) begin
				hit          = RAR_HIT_SER;
				hit_port     = RAR_PSEL_W'(i);
				remap_addr   = ser_addr[i*RAR_DW+RAR_ADDR_LSB +: RAR_AW];
				hit_auto_ack = ser_alias[i*RAR_DW+RAR_AACK_BIT];
			end
		end
	end

endmodule

// file: rar_remote_i2c_alias_remap.sv
// rar_remote_i2c_alias_remap: per-receive-port serializer id, alias and target remap bank.
// assumes: local I2C target logic delivers decoded register byte accesses and transaction
// addresses on this clock; forward-channel ids and lock come from the link logic, same clock.
//
// Notes on behaviour
// - each receive port has its own bank; accesses reach the port-selected copy.
// - forward-channel id fills remote serializer address; software may overwrite it.
// - hold bit set stops forward-channel updates and keeps the written address.
// - transaction matching serializer alias is remapped to remote serializer address.
// - zero serializer alias disables remote access; never decodes as a match.
// - auto-acknowledge set acks every serializer write regardless of lock or remote answer.
// - target alias 0 match remaps to entry 0 physical address, sent over control channel.
// - entries 1 and 2 remap likewise; bit 0 of each entry is reserved.
`timescale 1ns/1ps
module rar_remote_i2c_alias_remap
	import rar_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	// clock and reset
	input  wire logic                                        clock,
	input  wire logic                                        rst,
	// register access from local I2C target
	input  wire logic                                        reg_wr_en,
	input  wire logic                                        reg_rd_en,
	input  wire logic [7:0]                                  reg_addr,
	input  wire logic [rar_pkg::RAR_DW-1:0]                  reg_wr_data,
	output logic      [rar_pkg::RAR_DW-1:0]                  reg_rd_data,
	output logic                                             reg_rd_valid,
	// forward channel, one lane per receive port
	input  wire logic [NUM_PORTS-1:0]                        fc_id_valid,
	input  wire logic [NUM_PORTS*rar_pkg::RAR_AW-1:0]        fc_id,
	input  wire logic [NUM_PORTS-1:0]                        fc_lock,
	// target alias values held outside this bank
	input  wire logic [NUM_PORTS*rar_pkg::RAR_NUM_TGT*rar_pkg::RAR_AW-1:0] tgt_alias,
	// local transaction address phase
	input  wire logic                                        txn_valid,
	input  wire logic [rar_pkg::RAR_AW-1:0]                  txn_addr,
	input  wire logic                                        txn_rnw,
	// remapped transaction toward the control channel
	output logic                                             fwd_valid,
	output logic      [rar_pkg::RAR_PSEL_W-1:0]              fwd_port,
	output logic      [rar_pkg::RAR_AW-1:0]                  fwd_addr,
	output logic                                             fwd_rnw,
	output logic                                             fwd_to_ser,
	output logic                                             fwd_auto_ack,
	output logic                                             fwd_link_up,
	output logic                                             txn_miss,
	// current port select for other port-specific banks
	output logic      [rar_pkg::RAR_PSEL_W-1:0]              port_sel
);
	import rar_pkg::*;

	// refuse port counts the select field cannot address
	generate
		if (NUM_PORTS < 1 || NUM_PORTS > RAR_MAX_PORTS) begin : g_bad_ports
			$error("rar_remote_i2c_alias_remap: NUM_PORTS out of range");
		end
	endgenerate

	// per-port storage, flattened
	logic [NUM_PORTS*RAR_DW-1:0]             ser_addr_w;
	logic [NUM_PORTS*RAR_DW-1:0]             ser_alias_w;
	logic [NUM_PORTS*RAR_NUM_TGT*RAR_AW-1:0] tgt_addr_w;
	logic [NUM_PORTS-1:0]                    bank_wr_w;
	logic                                    psel_wr_w;

	// decode results
	rar_hit_e                hit_w;
	logic [RAR_PSEL_W-1:0]   hit_port_w;
	logic [RAR_AW-1:0]       remap_w;
	logic                    hit_aack_w;

	// read path
	logic [RAR_DW-1:0]       rd_d;
	logic [RAR_DW-1:0]       sel_ser_addr_w;
	logic [RAR_DW-1:0]       sel_ser_alias_w;
	logic [RAR_NUM_TGT*RAR_AW-1:0] sel_tgt_w;

	// ---------------------------------------------------------------
	// port select register
	// ---------------------------------------------------------------
	assign psel_wr_w = reg_wr_en && reg_addr == RAR_OFS_PORT_SEL;

	// a select beyond the fitted ports is ignored so writes never vanish into nothing
	always_ff @(posedge clock) begin
		if (rst) begin
			port_sel <= RAR_RST_VAL[RAR_PSEL_W-1:0];
		end else if (psel_wr_w &&
			32'(reg_wr_data[RAR_PSEL_LSB +: RAR_PSEL_W]) < NUM_PORTS) begin
			port_sel <= reg_wr_data[RAR_PSEL_LSB +: RAR_PSEL_W];
		end
	end

	// ---------------------------------------------------------------
	// per-port banks
	// ---------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_bank
			assign bank_wr_w[p] = reg_wr_en && (32'(port_sel) == p);
			rar_port_bank u_bank (
				.clock       (clock),
				.rst         (rst),
				.wr_en       (bank_wr_w[p]),
				.wr_addr     (reg_addr),
				.wr_data     (reg_wr_data),
				.fc_id_valid (fc_id_valid[p]),
				.fc_id       (fc_id[p*RAR_AW +: RAR_AW]),
				.ser_addr_q  (ser_addr_w[p*RAR_DW +: RAR_DW]),
				.ser_alias_q (ser_alias_w[p*RAR_DW +: RAR_DW]),
				.tgt_addr_q  (tgt_addr_w[p*RAR_NUM_TGT*RAR_AW +: RAR_NUM_TGT*RAR_AW])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// register read, one cycle after the strobe
	// ---------------------------------------------------------------
	assign sel_ser_addr_w  = ser_addr_w[port_sel*RAR_DW +: RAR_DW];
	assign sel_ser_alias_w = ser_alias_w[port_sel*RAR_DW +: RAR_DW];
	assign sel_tgt_w       = tgt_addr_w[port_sel*RAR_NUM_TGT*RAR_AW +: RAR_NUM_TGT*RAR_AW];

	always_comb begin
		rd_d = RAR_UNMAPPED_VAL;
		case (reg_addr)
			RAR_OFS_PORT_SEL: begin
				rd_d = RAR_DW'(port_sel);
			end
			RAR_OFS_SER_ADDR: begin
				rd_d = sel_ser_addr_w;
			end
			RAR_OFS_SER_ALIAS: begin
				rd_d = sel_ser_alias_w;
			end
			RAR_OFS_TGT0: begin
				rd_d = {sel_tgt_w[0*RAR_AW +: RAR_AW], 1'b0};
			end
			RAR_OFS_TGT1: begin
				rd_d = {sel_tgt_w[1*RAR_AW +: RAR_AW], 1'b0};
			end
			RAR_OFS_TGT2: begin
				rd_d = {sel_tgt_w[2*RAR_AW +: RAR_AW], 1'b0};
			end
			default: begin
				rd_d = RAR_UNMAPPED_VAL;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rd_data <= RAR_RST_VAL;
		end else if (reg_rd_en) begin
			reg_rd_data <= rd_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
		end
	end

	// ---------------------------------------------------------------
	// alias decode and remap
	// ---------------------------------------------------------------
	rar_remap_match #(
		.NUM_PORTS (NUM_PORTS)
	) u_match (
		.txn_addr     (txn_addr),
		.ser_addr     (ser_addr_w),
		.ser_alias    (ser_alias_w),
		.tgt_alias    (tgt_alias),
		.tgt_addr     (tgt_addr_w),
		.hit          (hit_w),
		.hit_port     (hit_port_w),
		.remap_addr   (remap_w),
		.hit_auto_ack (hit_aack_w)
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			fwd_valid <= 1'b0;
			txn_miss  <= 1'b0;
		end else begin
			fwd_valid <= txn_valid && hit_w != RAR_HIT_NONE;
			txn_miss  <= txn_valid && hit_w == RAR_HIT_NONE;
		end
	end

	// payload holds until the next accepted transaction
	always_ff @(posedge clock) begin
		if (rst) begin
			fwd_port   <= '0;
			fwd_addr   <= '0;
			fwd_rnw    <= 1'b0;
			fwd_to_ser <= 1'b0;
		end else if (txn_valid && hit_w != RAR_HIT_NONE) begin
			fwd_port   <= hit_port_w;
			fwd_addr   <= remap_w;
			fwd_rnw    <= txn_rnw;
			fwd_to_ser <= hit_w == RAR_HIT_SER;
		end
	end

	// lock is reported but deliberately not part of the auto-ack term
	always_ff @(posedge clock) begin
		if (rst) begin
			fwd_auto_ack <= 1'b0;
			fwd_link_up  <= 1'b0;
		end else if (txn_valid && hit_w != RAR_HIT_NONE) begin
			fwd_auto_ack <= hit_w == RAR_HIT_SER && !txn_rnw && hit_aack_w;
			fwd_link_up  <= fc_lock[hit_port_w];
		end
	end

endmodule

// file: rar_remote_i2c_alias_remap_asserts.sv
// checker for the alias / remap register bank, ports of the top module only.
// assumes: single clock, synchronous active-high reset.
`timescale 1ns/1ps
module rar_alias_asserts
	import rar_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	// clock and reset
	input wire logic                         clock,
	input wire logic                         rst,
	// register access
	input wire logic                         reg_wr_en,
	input wire logic                         reg_rd_en,
	input wire logic [7:0]                   reg_addr,
	input wire logic [rar_pkg::RAR_DW-1:0]   reg_wr_data,
	input wire logic [rar_pkg::RAR_DW-1:0]   reg_rd_data,
	input wire logic                         reg_rd_valid,
	// decode
	input wire logic                         txn_valid,
	input wire logic [rar_pkg::RAR_AW-1:0]   txn_addr,
	input wire logic                         txn_rnw,
	input wire logic                         fwd_valid,
	input wire logic                         fwd_rnw,
	input wire logic                         fwd_auto_ack,
	input wire logic                         txn_miss,
	input wire logic [rar_pkg::RAR_PSEL_W-1:0] port_sel
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read answer missing");
	rd_pulse_a: assert property (!reg_rd_en |=> !reg_rd_valid)
		else $error("read answer without a strobe");
	unmapped_zero_a: assert property (reg_rd_en && reg_addr != 8'h4C && (reg_addr < 8'h5B || reg_addr > 8'h5F)
		|=> reg_rd_data == 8'h00) else $error("unmapped offset read not zero");
	reserved_bit_a: assert property (reg_rd_en && reg_addr inside {[8'h5D:8'h5F]} |=> !reg_rd_data[0])
		else $error("target entry bit 0 reads one");
	zero_alias_a: assert property (txn_valid && txn_addr == 7'h00 |=> txn_miss && !fwd_valid)
		else $error("zero address decoded as a hit");
	decode_once_a: assert property (txn_valid |=> fwd_valid != txn_miss)
		else $error("decode gave neither or both results");
	no_txn_quiet_a: assert property (!txn_valid |=> !fwd_valid && !txn_miss)
		else $error("decode result without a transaction");
	rnw_copy_a: assert property (txn_valid ##1 fwd_valid |-> fwd_rnw == $past(txn_rnw))
		else $error("direction not carried through");
	read_no_ack_a: assert property (fwd_valid && fwd_rnw |-> !fwd_auto_ack)
		else $error("auto acknowledge on a read");
	port_write_a: assert property (reg_wr_en && reg_addr == 8'h4C && 32'(reg_wr_data[1:0]) < NUM_PORTS
		|=> port_sel == $past(reg_wr_data[1:0])) else $error("port select not taken");
	port_range_a: assert property (port_sel < NUM_PORTS) else $error("port select out of range");
endmodule

bind rar_remote_i2c_alias_remap rar_alias_asserts #(.NUM_PORTS(NUM_PORTS)) u_chk (.clock(clock), .rst(rst),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
	.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .txn_valid(txn_valid), .txn_addr(txn_addr),
	.txn_rnw(txn_rnw), .fwd_valid(fwd_valid), .fwd_rnw(fwd_rnw), .fwd_auto_ack(fwd_auto_ack),
	.txn_miss(txn_miss), .port_sel(port_sel));

// file: rar_remote_i2c_alias_remap_test.sv
// testbench for the alias / remap bank: register, forward-channel and decode sequences.
// assumes: rar_fc_model drives the forward-channel lanes.
`timescale 1ns/1ps
module rar_remote_i2c_alias_remap_test;
	import rar_pkg::*;
	logic        clock = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, send = 1'b0;
	logic        txn_valid = 1'b0, txn_rnw = 1'b0, rd_valid, fv, frnw, fser, fack, flink, miss;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rd_data;
	logic [6:0]  txn_addr = 7'h00, fc_tx = 7'h00, faddr;
	logic [1:0]  fc_port = 2'h0, fport, psel;
	logic [3:0]  fc_v, fc_lk;
	logic [27:0] fc_id;
	logic [83:0] tgt_alias = '0;
	int          err_total = 0, samples_checked = 0, cyc = 0;

	rar_fc_model #(.NP(4)) fcm (.clock(clock), .rst(rst), .send(send), .port(fc_port), .id(fc_tx),
		.fc_id_valid(fc_v), .fc_id(fc_id), .fc_lock(fc_lk));
	rar_remote_i2c_alias_remap #(.NUM_PORTS(4)) dut (.clock(clock), .rst(rst), .reg_wr_en(wr_en),
		.reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid),
		.fc_id_valid(fc_v), .fc_id(fc_id), .fc_lock(fc_lk), .tgt_alias(tgt_alias), .txn_valid(txn_valid),
		.txn_addr(txn_addr), .txn_rnw(txn_rnw), .fwd_valid(fv), .fwd_port(fport), .fwd_addr(faddr),
		.fwd_rnw(frnw), .fwd_to_ser(fser), .fwd_auto_ack(fack), .fwd_link_up(flink), .txn_miss(miss),
		.port_sel(psel));

	initial begin
		forever #5 clock = ~clock;
	end

	task automatic final_report();
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) {wr_en, addr, wdata} <= {1'b1, a, d};
		@(posedge clock) wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock) {rd_en, addr} <= {1'b1, a};
		@(posedge clock) rd_en <= 1'b0;
		#1 chk({7'h00, rd_valid, rd_data}, {8'h01, exp});
	endtask

	// expected: miss, valid, rnw, port, addr, to serializer, write auto-acknowledge, link_up
	task automatic txn(input logic [6:0] a, input logic rnw, input logic [14:0] exp);
		@(posedge clock) {txn_valid, txn_addr, txn_rnw} <= {1'b1, a, rnw};
		@(posedge clock) txn_valid <= 1'b0;
		#1 chk({1'b0, miss, fv, frnw, fport, faddr, fser, fack, flink}, {1'b0, exp});
	endtask

	task automatic fc(input logic [1:0] p, input logic [6:0] id);
		@(posedge clock) {send, fc_port, fc_tx} <= {1'b1, p, id};
		@(posedge clock) send <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			final_report();
		end
	end

	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(8'h4C, 8'h00);
		for (int o = 8'h5B; o <= 8'h5F; o++) rd(o[7:0], 8'h00);
		wr(8'h60, 8'hA5);
		rd(8'h60, 8'h00);
		wr(8'h4C, 8'h01);
		wr(8'h4C, 8'h05); // only bits 1:0 select, upper bits read back zero
		rd(8'h4C, 8'h01);
		chk({14'h0000, psel}, 16'h0001);
		fc(2'h1, 7'h30);
		rd(8'h5B, 8'h60);
		wr(8'h5B, 8'h21);
		fc(2'h1, 7'h33);
		rd(8'h5B, 8'h21);
		wr(8'h5C, 8'h81);
		txn(7'h40, 1'b0, {2'b01, 1'b0, 2'h1, 7'h10, 3'b111});
		txn(7'h40, 1'b1, {2'b01, 1'b1, 2'h1, 7'h10, 3'b101});
		wr(8'h5D, 8'hFF);
		wr(8'h5E, 8'h44);
		wr(8'h5F, 8'h67);
		rd(8'h5D, 8'hFE);
		rd(8'h5F, 8'h66);
		@(posedge clock) tgt_alias[3*7+:21] <= {7'h52, 7'h51, 7'h50};
		txn(7'h50, 1'b0, {2'b01, 1'b0, 2'h1, 7'h7F, 3'b001});
		txn(7'h51, 1'b0, {2'b01, 1'b0, 2'h1, 7'h22, 3'b001});
		txn(7'h52, 1'b1, {2'b01, 1'b1, 2'h1, 7'h33, 3'b001});
		txn(7'h00, 1'b0, {2'b10, 1'b1, 2'h1, 7'h33, 3'b001});
		txn(7'h7E, 1'b0, {2'b10, 1'b1, 2'h1, 7'h33, 3'b001});
		wr(8'h4C, 8'h00);
		rd(8'h5C, 8'h00);
		rd(8'h5B, 8'h00);
		// port 0 takes the same alias: lowest port wins, no lock on port 0
		wr(8'h5C, 8'h80);
		txn(7'h40, 1'b0, {2'b01, 1'b0, 2'h0, 7'h00, 3'b100});
		wr(8'h5C, 8'h81);
		txn(7'h40, 1'b0, {2'b01, 1'b0, 2'h0, 7'h00, 3'b110});
		final_report();
	end
endmodule
